// ---- logic/asrp_pkg.sv ----
// Shared constants and types for the converter serial readout port
package asrp_pkg;
  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int unsigned FRAME_BITS   = 19;
  localparam int unsigned RESULT_BITS  = 16;
  localparam int unsigned ADDR_BITS    = 5;
  localparam logic [4:0]  LAST_EDGE    = 5'h13;
  localparam logic [4:0]  ADDR_DONE    = 5'h05;
  localparam logic [4:0]  CNT_ZERO     = 5'h00;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned SCK_DIV      = 8;
  localparam int unsigned HALF_DIV     = SCK_DIV / 2;
  localparam logic [1:0]  HALF_LAST    = 2'(HALF_DIV - 1);
  localparam logic [15:0] CONV_CYCLES  = 16'h0400;
  localparam logic [7:0]  HOST_HALF    = 8'h04;
  localparam logic [4:0]  ADDR_RESET   = 5'h00;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  // ****************************************************************
  // Host register map (APB byte offsets)
  // ****************************************************************
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_RESULT    = 8'h08;
  localparam int unsigned CTRL_START   = 0;
  localparam int unsigned CTRL_HOLD    = 1;
  localparam int unsigned CTRL_ADDR_LO = 8;
  localparam int unsigned ST_BUSY      = 0;
  localparam int unsigned ST_DONE      = 1;
  localparam int unsigned ST_EOC       = 2;

  typedef enum logic [1:0] {
    ASRP_CONVERT,
    ASRP_SLEEP,
    ASRP_DATA
  } asrp_state_t;
endpackage

// ---- logic/asrp_link_if.sv ----
// Serial link between converter port and host controller
`timescale 1ns/1ps
`default_nettype none
interface asrp_link_if;
  logic cs_n;
  logic sck_host;
  logic sck_host_oe_n;
  logic sck_dev;
  logic sck_dev_oe_n;
  logic sdi;
  logic sdo;
  logic sdo_oe_n;
  // Resolved clock level; floating reads high through the pull-up
  wire  sck = !sck_dev_oe_n ? sck_dev :
              !sck_host_oe_n ? sck_host : 1'b1;
  wire  sdo_line = !sdo_oe_n ? sdo : 1'b1;

  modport device (input cs_n, input sck, input sdi,
                  output sck_dev, output sck_dev_oe_n,
                  output sdo, output sdo_oe_n);
  modport host (output cs_n, output sck_host, output sck_host_oe_n,
                output sdi, input sck, input sdo_line);
endinterface
`default_nettype wire

// ---- logic/asrp_device.sv ----
// Converter end of the serial readout port
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
module asrp_device
  import asrp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  asrp_link_if.device      link,
  input  wire logic [16:0] conv_value,
  input  wire logic        rejection_freq_select,
  output logic [4:0]       channel_sel,
  output logic             converting,
  output logic             internal_mode
);
  import asrp_pkg::*;

  // ****************************************************************
  // Link sampling and edges
  // ****************************************************************
  asrp_state_t state;
  logic        cs_q;
  logic        sck_q;
  logic        boot;
  logic [15:0] conv_cnt;
  logic [17:0] shreg;
  logic [4:0]  addr_sh;
  logic [4:0]  edge_cnt;
  logic [1:0]  div_cnt;
  logic        sck_out;
  logic        sdo_bit;

  wire cs_fall  = cs_q && !link.cs_n;
  wire cs_rise  = !cs_q && link.cs_n;
  wire sck_rise = internal_mode ? (div_cnt == HALF_LAST && !sck_out)
                                : (!sck_q && link.sck);
  wire sck_fall = internal_mode ? (div_cnt == HALF_LAST && sck_out)
                                : (sck_q && !link.sck);
  wire conv_done = (state == ASRP_CONVERT) && (conv_cnt == 16'h0000);
  wire in_data   = (state == ASRP_DATA);
  // Rejection pin only scales conversion length in silicon; one rate here
  wire unused_ok = rejection_freq_select;
  wire end_frame = in_data && sck_fall && edge_cnt == LAST_EDGE;
  wire abort     = in_data && cs_rise;
  wire go_data   = (state == ASRP_SLEEP) && !link.cs_n && sck_rise;

  assign converting = (state == ASRP_CONVERT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_q  <= 1'b1;
      sck_q <= 1'b1;
      boot  <= 1'b1;
    end else begin
      cs_q  <= link.cs_n;
      sck_q <= link.sck;
      boot  <= 1'b0;
    end
  end

  // ****************************************************************
  // Clock mode select
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      internal_mode <= 1'b1;
    end else if (boot || cs_fall) begin
      internal_mode <= link.sck;
    end
  end

  // Internal clock: toggle every half period, only while selected in sleep state or in data state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 2'b00;
      sck_out <= 1'b1;
    end else if (internal_mode && (in_data || go_data ||
                 (state == ASRP_SLEEP && !link.cs_n))) begin
      div_cnt <= div_cnt + 2'b01;
      if (div_cnt == HALF_LAST) begin
        sck_out <= !sck_out;
      end
    end else begin
      div_cnt <= 2'b00;
      sck_out <= 1'b1;
    end
  end

  // Clock driven only while selected, so a deselected pin follows the host clock
  assign link.sck_dev      = sck_out;
  assign link.sck_dev_oe_n = !(internal_mode && !link.cs_n);

  // ****************************************************************
  // Conversion and state sequencing
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= ASRP_CONVERT;
      conv_cnt <= CONV_CYCLES;
    end else if (abort || end_frame) begin
      state    <= ASRP_CONVERT;
      conv_cnt <= CONV_CYCLES;
    end else if (conv_done) begin
      state    <= ASRP_SLEEP;
    end else if (state == ASRP_CONVERT) begin
      conv_cnt <= conv_cnt - 16'h0001;
    end else if (go_data) begin
      state    <= ASRP_DATA;
    end
  end

  // ****************************************************************
  // Shift paths
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg    <= {2'b00, RESULT_RESET};
      edge_cnt <= CNT_ZERO;
      addr_sh  <= ADDR_RESET;
      channel_sel <= ADDR_RESET;
      sdo_bit  <= 1'b1;
    end else begin
      if (conv_done) begin
        shreg   <= {1'b0, conv_value};
        sdo_bit <= 1'b0;
      end
      // Completion cycle must not reassert busy over the fresh flag
      if (state == ASRP_CONVERT && !conv_done) begin
        sdo_bit  <= 1'b1;
        edge_cnt <= CNT_ZERO;
      end
      if ((go_data || in_data) && sck_rise && edge_cnt < LAST_EDGE) begin
        edge_cnt <= edge_cnt + 5'h01;
        if (edge_cnt < ADDR_DONE) begin
          addr_sh <= {addr_sh[3:0], link.sdi};
        end
        if (edge_cnt + 5'h01 == ADDR_DONE) begin
          channel_sel <= {addr_sh[3:0], link.sdi};
        end
      end
      if (in_data && sck_fall && edge_cnt < LAST_EDGE) begin
        sdo_bit <= shreg[17];
        shreg   <= {shreg[16:0], 1'b0};
      end
    end
  end

  assign link.sdo      = sdo_bit;
  assign link.sdo_oe_n = link.cs_n;
endmodule
`default_nettype wire

// ---- logic/asrp_host.sv ----
// Host controller end with APB register access
`timescale 1ns/1ps
`default_nettype none
module asrp_host
  import asrp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  asrp_link_if.host        link
);
  import asrp_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic        hold_sel;
  logic [4:0]  next_addr;
  logic        busy;
  logic        done;
  logic [18:0] rx;
  logic [4:0]  tx;
  logic [4:0]  bit_cnt;
  logic [7:0]  half_cnt;
  logic        sck_r;
  logic        cs_r;

  wire wr     = psel && penable && pwrite;
  wire wr_ctl = wr && paddr == REG_CTRL;
  wire start  = wr_ctl && pwdata[CTRL_START] && !busy;
  wire mapped = paddr == REG_CTRL || paddr == REG_STATUS ||
                paddr == REG_RESULT;
  wire tick   = busy && half_cnt == HOST_HALF;
  // Releasing select mid-frame aborts; clock parks low for the next fall
  wire quit   = wr_ctl && !pwdata[CTRL_HOLD] && busy;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = paddr == REG_CTRL ?
                     {19'h0, next_addr, 6'h0, hold_sel, 1'b0} :
                   paddr == REG_STATUS ?
                     {29'h0, link.sdo_line, done, busy} :
                   paddr == REG_RESULT ? {13'h0, rx} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_sel  <= 1'b0;
      next_addr <= ADDR_RESET;
    end else if (wr_ctl) begin
      hold_sel  <= pwdata[CTRL_HOLD];
      next_addr <= pwdata[CTRL_ADDR_LO +: ADDR_BITS];
    end
  end

  // ****************************************************************
  // Link sequencer: clock idles low to keep external mode
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy     <= 1'b0;
      done     <= 1'b0;
      rx       <= 19'h0;
      tx       <= ADDR_RESET;
      bit_cnt  <= CNT_ZERO;
      half_cnt <= 8'h00;
      sck_r    <= 1'b0;
      cs_r     <= 1'b1;
    end else begin
      half_cnt <= tick || !busy ? 8'h00 : half_cnt + 8'h01;
      if (wr_ctl) begin
        cs_r <= !pwdata[CTRL_HOLD];
      end
      if (quit) begin
        busy  <= 1'b0;
        sck_r <= 1'b0;
      end else if (start && !link.sdo_line && !cs_r) begin
        busy    <= 1'b1;
        done    <= 1'b0;
        tx      <= next_addr;
        bit_cnt <= CNT_ZERO;
      end else if (tick) begin
        sck_r <= !sck_r;
        if (!sck_r) begin
          rx <= {rx[17:0], link.sdo_line};
          bit_cnt <= bit_cnt + 5'h01;
        end else begin
          tx <= {tx[3:0], 1'b0};
          if (bit_cnt == LAST_EDGE) begin
            busy <= 1'b0;
            done <= 1'b1;
            cs_r <= !hold_sel;
          end
        end
      end
    end
  end

  assign link.cs_n          = cs_r;
  assign link.sck_host      = sck_r;
  assign link.sck_host_oe_n = 1'b0;
  assign link.sdi           = tx[4];
endmodule
`default_nettype wire

// ---- bench/asrp_link_props.sv ----
// Link protocol checks for the serial readout port pair
`timescale 1ns/1ps
`default_nettype none
module asrp_link_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sck_dev_oe_n,
  input wire logic sdo,
  input wire logic sdo_oe_n
);
  logic [4:0] rise_cnt;
  logic       sck_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************
  // Frame edge count
  // ****************
  // Cleared at the last fall, so held-low select still frames cleanly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rise_cnt <= 5'h00;
    else if (cs_n || (rise_cnt == 5'h13 && sck_q && !sck))
      rise_cnt <= 5'h00;
    else if (!sck_q && sck)
      rise_cnt <= rise_cnt + 5'h01;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sck_q <= 1'b0;
    else
      sck_q <= sck;
  end
  a_sdo_release: assert property (cs_n && $past(cs_n) |-> sdo_oe_n)
    else $error("data output driven while deselected");
  a_shift_edge: assert property (!cs_n && $past(!cs_n) && sck
    && $past(sck) && $past(sck, 2) && $past(sck, 3) |-> $stable(sdo))
    else $error("data output moved while clock high");
  a_ext_mode: assert property ($fell(cs_n) && !sck
    |=> sck_dev_oe_n [*8])
    else $error("device drove clock after low select fall");
  a_sck_low_sel: assert property ($fell(cs_n) |-> !sck)
    else $error("clock not low at select fall");
  a_flag_first: assert property (!cs_n && !sck_q && sck
    && rise_cnt == 5'h00 |-> !sdo)
    else $error("flag not low at first rising edge");
  a_filler_zero: assert property (!cs_n && !sck_q && sck
    && rise_cnt == 5'h01 |-> !sdo)
    else $error("filler bit not low");
  a_frame_end: assert property (rise_cnt == 5'h13 && sck_q
    && !sck |-> ##[1:3] sdo)
    else $error("output not raised after last falling edge");
  a_sleep_hold: assert property (!cs_n && $past(!cs_n)
    && rise_cnt == 5'h00 && $past(rise_cnt, 4) == 5'h00 && !sck
    && $past(!sdo) |-> !sdo)
    else $error("sleep flag lost without a clock edge");
  c_frame: cover property (rise_cnt == 5'h13 && sck_q && !sck);
  c_abort: cover property ($rose(cs_n) && rise_cnt != 5'h00);
  c_select: cover property ($fell(cs_n) && !sck);
endmodule
`default_nettype wire

// ---- bench/tb_adc_serial_readout_port.sv ----
// Self-checking bench for the converter readout port pair
`timescale 1ns/1ps
`default_nettype none
module tb_adc_serial_readout_port;
  import asrp_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [16:0] conv_value;
  logic [4:0]  channel_sel;
  logic        converting;
  logic        internal_mode;
  logic [31:0] rd;
  logic        err;
  int          bad_count;
  int          total_checks;
  asrp_link_if link ();
  asrp_device asrp_device_i (.pclk(pclk), .presetn(presetn), .link(link),
    .conv_value(conv_value), .rejection_freq_select(1'b0),
    .channel_sel(channel_sel), .converting(converting),
    .internal_mode(internal_mode));
  asrp_host asrp_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  asrp_link_props asrp_link_props_i (.pclk(pclk), .presetn(presetn),
    .cs_n(link.cs_n), .sck(link.sck), .sck_dev_oe_n(link.sck_dev_oe_n),
    .sdo(link.sdo), .sdo_oe_n(link.sdo_oe_n));
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;
  // ****************
  // Shared tasks
  // ****************
  task automatic check(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded so a stuck status bit ends as a mismatch, not a hang
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (rd[b] !== v && n < 3000);
    check("status poll", {31'h0, rd[b]}, {31'h0, v});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    check("mode", {31'h0, internal_mode}, 32'h0);
    check("sdo off", {31'h0, link.sdo_oe_n}, 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    $display("test reset done");
  endtask
  task automatic t_read(input logic [4:0] ch, input logic [16:0] v);
    conv_value <= v;
    apb(1'b1, REG_CTRL, {19'h0, ch, 8'h02});
    poll(ST_EOC, 1'b0);
    apb(1'b1, REG_CTRL, {19'h0, ch, 8'h03});
    poll(ST_BUSY, 1'b0);
    apb(1'b0, REG_RESULT, 32'h0);
    check("result", rd, {15'h0, v});
    check("channel", {27'h0, channel_sel}, {27'h0, ch});
    check("reconvert", {31'h0, converting}, 32'h1);
    $display("test read done");
  endtask
  // Abort lands in the first bits, before the address is complete
  task automatic t_abort(input logic [4:0] ch);
    int n;
    apb(1'b1, REG_CTRL, 32'h00000302);
    poll(ST_EOC, 1'b0);
    apb(1'b1, REG_CTRL, 32'h00000303);
    n = 0;
    while (link.sck !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    apb(1'b1, REG_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    check("kept ch", {27'h0, channel_sel}, {27'h0, ch});
    check("abort conv", {31'h0, converting}, 32'h1);
    check("sdo off", {31'h0, link.sdo_oe_n}, 32'h1);
    poll(ST_BUSY, 1'b0);
    $display("test abort done");
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    bad_count++;
    results();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    conv_value = 17'h0;
    bad_count = 0;
    total_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset();
    t_read(5'h15, 17'h1ffff);
    t_read(5'h0a, 17'h08000);
    t_abort(5'h0a);
    t_read(5'h1f, 17'h00001);
    results();
  end
endmodule
`default_nettype wire
